// ### hdl/station_filter.v
// Function
// - Address-high holds address bits 47:32 in bits 15:0, upper bits reserved
// - Eeprom locations 5 and 6 load address-high bytes 0 and 1
// - Address-low holds bits 31:0, loaded from eeprom locations 1 to 4
// - Eeprom load happens only when a programmed eeprom is detected
// - Address contents undefined until load ends; host writes only afterwards
// - Address-low byte 0 matches first octet, address-high byte 1 the sixth
// - Hash table is 64 bits: upper register high half, lower register low half
// - Hash index from destination address selects one table bit
// - Index top bit picks register, remaining five bits pick bit position
// - Index zero is lower bit 0; all ones is upper bit 31
// - Group frame accepted when selected bit is 1, rejected when 0
// - Pass-all-group-frames set accepts every group frame
// - Register index bits 10:6 select the phy register
// - Write-select bit 1 chooses write from data register, else read
// - Software writes busy bit 0 as 1 to start a cycle
// - Busy stays 1 for the whole cycle, cleared on completion
// - Data register invalid during read until busy clears
// - Data register carries 16-bit phy value in bits 15:0
//
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/1ps
`include "station_filter_defs.vh"

module station_filter #(
    parameter MDC_HALF = `MDC_HALF_CYCLES
) (
    input wire clk,
    input wire rst,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg hreadyout,
    output reg hresp,
    output reg [31:0] hrdata,
    input wire ee_programmed,
    input wire ee_valid,
    input wire [2:0] ee_loc,
    input wire [7:0] ee_data,
    input wire ee_done,
    output reg init_done,
    input wire rx_start,
    input wire rx_valid,
    input wire [7:0] rx_byte,
    output reg da_done,
    output reg station_match,
    output reg group_frame,
    output reg group_accept,
    output reg mdc,
    output reg mdio_out,
    output reg mdio_oe,
    input wire mdio_in
);

// ==========================================
// Functions
function [31:0] crc_byte;
    input [31:0] crc;
    input [7:0] data;
    integer i;
    reg [31:0] c;
    begin
        c = crc;
        for (i = 0; i < 8; i = i + 1) begin
            if (c[31] ^ data[i]) begin
                c = {c[30:0], 1'b0} ^ `CRC_POLY;
            end else begin
                c = {c[30:0], 1'b0};
            end
        end
        crc_byte = c;
    end
endfunction

function [7:0] addr_octet;
    input [47:0] addr;
    input [2:0] k;
    begin
        case (k)
            3'h0: addr_octet = addr[7:0];
            3'h1: addr_octet = addr[15:8];
            3'h2: addr_octet = addr[23:16];
            3'h3: addr_octet = addr[31:24];
            3'h4: addr_octet = addr[39:32];
            default: addr_octet = addr[47:40];
        endcase
    end
endfunction

// ==========================================
// Registers
reg [31:0] addr_high;
reg [31:0] addr_low;
reg [31:0] hash_upper;
reg [31:0] hash_lower;
reg [15:0] acc_ctl;
reg [15:0] phy_data;
reg pass_all;
reg busy;

reg wr_pending;
reg [3:0] wr_idx;
wire addr_phase;
wire [3:0] a_idx;
wire [47:0] station;
wire [7:0] ee_k_byte;

assign addr_phase = hsel & htrans[1] & hready;
assign a_idx = haddr[5:2];
assign station = {addr_high[15:0], addr_low};
assign ee_k_byte = ee_data;

// ==========================================
// Bus slave
always @(posedge clk) begin
    if (rst) begin
        hreadyout <= 1'b1;
        hresp <= 1'b0;
        hrdata <= 32'h00000000;
        wr_pending <= 1'b0;
        wr_idx <= 4'h0;
    end else begin
        hreadyout <= 1'b1;
        hresp <= 1'b0;
        wr_pending <= addr_phase & hwrite & (haddr[31:6] == 26'h0000000);
        wr_idx <= a_idx;
        if (addr_phase & ~hwrite) begin
            hrdata <= 32'h00000000;
            if (haddr[31:6] == 26'h0000000) begin
                case (a_idx)
                    `IDX_FILTER_CTRL: begin
                        hrdata[`CTRL_PASS_ALL_BIT] <= pass_all;
                        hrdata[`CTRL_INIT_DONE_BIT] <= init_done;
                    end
                    `IDX_ADDR_HIGH: hrdata <= {16'h0000, addr_high[15:0]};
                    `IDX_ADDR_LOW: hrdata <= addr_low;
                    `IDX_HASH_UPPER: hrdata <= hash_upper;
                    `IDX_HASH_LOWER: hrdata <= hash_lower;
                    `IDX_PHY_ACCESS: hrdata <= {16'h0000, acc_ctl[15:1], busy};
                    `IDX_PHY_DATA: hrdata <= {16'h0000, phy_data};
                    default: hrdata <= 32'h00000000;
                endcase
            end
        end
    end
end

// ==========================================
// Management engine
reg [63:0] shift;
reg [6:0] bit_cnt;
reg [3:0] div_cnt;
reg running;
reg is_read;
wire start_req;
wire mdc_edge;

assign start_req = wr_pending & (wr_idx == `IDX_PHY_ACCESS) & ~busy
                 & hwdata[`ACC_BUSY_BIT];
assign mdc_edge = (div_cnt == MDC_HALF - 1);

always @(posedge clk) begin
    if (rst) begin
        addr_high <= `RST_ADDR_HIGH;
        addr_low <= `RST_ADDR_LOW;
        hash_upper <= `RST_HASH;
        hash_lower <= `RST_HASH;
        acc_ctl <= 16'h0000;
        phy_data <= 16'h0000;
        pass_all <= 1'b0;
        init_done <= 1'b0;
        busy <= 1'b0;
        running <= 1'b0;
        is_read <= 1'b0;
        shift <= 64'h0000000000000000;
        bit_cnt <= 7'h00;
        div_cnt <= 4'h0;
        mdc <= 1'b0;
        mdio_out <= 1'b1;
        mdio_oe <= 1'b0;
    end else begin
        // Eeprom load of station address
        if (~init_done) begin
            if (ee_valid & ee_programmed) begin
                case (ee_loc)
                    3'h1: addr_low[7:0] <= ee_k_byte;
                    3'h2: addr_low[15:8] <= ee_k_byte;
                    3'h3: addr_low[23:16] <= ee_k_byte;
                    3'h4: addr_low[31:24] <= ee_k_byte;
                    3'h5: addr_high[7:0] <= ee_k_byte;
                    3'h6: addr_high[15:8] <= ee_k_byte;
                    default: addr_low <= addr_low;
                endcase
            end
            if (ee_done) begin
                init_done <= 1'b1;
            end
        end
        // Host writes
        if (wr_pending) begin
            case (wr_idx)
                `IDX_FILTER_CTRL: pass_all <= hwdata[`CTRL_PASS_ALL_BIT];
                `IDX_ADDR_HIGH: begin
                    if (init_done) begin
                        addr_high <= {16'h0000, hwdata[15:0]};
                    end
                end
                `IDX_ADDR_LOW: begin
                    if (init_done) begin
                        addr_low <= hwdata;
                    end
                end
                `IDX_HASH_UPPER: hash_upper <= hwdata;
                `IDX_HASH_LOWER: hash_lower <= hwdata;
                `IDX_PHY_ACCESS: begin
                    if (~busy) begin
                        acc_ctl <= {hwdata[15:1], 1'b0};
                    end
                end
                `IDX_PHY_DATA: begin
                    if (~busy) begin
                        phy_data <= hwdata[15:0];
                    end
                end
                default: pass_all <= pass_all;
            endcase
        end
        // Start of a management frame
        if (start_req) begin
            busy <= 1'b1;
            running <= 1'b1;
            is_read <= ~hwdata[`ACC_WRITE_BIT];
            // First preamble bit set up before mdc rises
            shift <= {31'h7FFFFFFF, `MDIO_START,
                      hwdata[`ACC_WRITE_BIT] ? `MDIO_OP_WRITE : `MDIO_OP_READ,
                      hwdata[`ACC_PHYAD_HI:`ACC_PHYAD_LO],
                      hwdata[`ACC_REGIDX_HI:`ACC_REGIDX_LO],
                      2'b10, phy_data, 1'b0};
            bit_cnt <= 7'h01;
            div_cnt <= 4'h0;
            mdc <= 1'b0;
            mdio_out <= 1'b1;
            mdio_oe <= 1'b1;
        end else if (running) begin
            if (mdc_edge) begin
                div_cnt <= 4'h0;
                mdc <= ~mdc;
                if (~mdc) begin
                    // Rising edge: sample read data
                    if (is_read & (bit_cnt > `MDIO_DATA_BIT)) begin
                        phy_data <= {phy_data[14:0], mdio_in};
                    end
                end else if (bit_cnt == `MDIO_FRAME_BITS) begin
                    running <= 1'b0;
                    busy <= 1'b0;
                    mdio_oe <= 1'b0;
                    mdio_out <= 1'b1;
                end
            end else begin
                div_cnt <= div_cnt + 4'h1;
            end
            // Drive next bit while clock is low
            if (mdc_edge & mdc & (bit_cnt != `MDIO_FRAME_BITS)) begin
                mdio_out <= shift[63];
                mdio_oe <= ~(is_read & (bit_cnt >= `MDIO_TA_BIT));
                shift <= {shift[62:0], 1'b0};
                bit_cnt <= bit_cnt + 7'h01;
            end
        end
    end
end

// ==========================================
// Receive address filter
reg [31:0] crc;
reg [2:0] rx_cnt;
reg match_acc;
reg group_bit;
wire [31:0] next_crc;
wire [5:0] hash_idx;
wire hash_hit;

assign next_crc = crc_byte(crc, rx_byte);
assign hash_idx = next_crc[31:26];
assign hash_hit = hash_idx[5] ? hash_upper[hash_idx[4:0]]
                              : hash_lower[hash_idx[4:0]];

always @(posedge clk) begin
    if (rst) begin
        crc <= `CRC_INIT;
        rx_cnt <= 3'h0;
        match_acc <= 1'b0;
        group_bit <= 1'b0;
        da_done <= 1'b0;
        station_match <= 1'b0;
        group_frame <= 1'b0;
        group_accept <= 1'b0;
    end else begin
        da_done <= 1'b0;
        if (rx_start) begin
            crc <= `CRC_INIT;
            rx_cnt <= 3'h0;
            match_acc <= 1'b1;
        end else if (rx_valid & (rx_cnt != `DA_BYTES)) begin
            crc <= next_crc;
            rx_cnt <= rx_cnt + 3'h1;
            if (rx_cnt == 3'h0) begin
                group_bit <= rx_byte[0];
            end
            if (rx_byte != addr_octet(station, rx_cnt)) begin
                match_acc <= 1'b0;
            end
            if (rx_cnt == `DA_BYTES - 3'h1) begin
                da_done <= 1'b1;
                station_match <= match_acc &
                    (rx_byte == addr_octet(station, rx_cnt));
                group_frame <= group_bit;
                group_accept <= group_bit & (pass_all | hash_hit);
            end
        end
    end
end

endmodule // station_filter

// ### pkg/station_filter_defs.vh
`ifndef STATION_FILTER_DEFS_VH
`define STATION_FILTER_DEFS_VH
// ==========================================
// Register indices (byte address = 4 x index)
`define IDX_FILTER_CTRL 4'h1
`define IDX_ADDR_HIGH 4'h2
`define IDX_ADDR_LOW 4'h3
`define IDX_HASH_UPPER 4'h4
`define IDX_HASH_LOWER 4'h5
`define IDX_PHY_ACCESS 4'h6
`define IDX_PHY_DATA 4'h7
// ==========================================
// Reset values
`define RST_ADDR_HIGH 32'h00000FFF
`define RST_ADDR_LOW 32'h0FFFFFFF
`define RST_HASH 32'h00000000
`define RST_PHY_ACCESS 32'h00000000
`define RST_PHY_DATA 32'h00000000
// ==========================================
// Field positions
`define ACC_PHYAD_HI 15
`define ACC_PHYAD_LO 11
`define ACC_REGIDX_HI 10
`define ACC_REGIDX_LO 6
`define ACC_WRITE_BIT 1
`define ACC_BUSY_BIT 0
`define CTRL_PASS_ALL_BIT 0
`define CTRL_INIT_DONE_BIT 31
// ==========================================
// Eeprom byte locations
`define EE_LOC_FIRST 3'h1
`define EE_LOC_LAST 3'h6
// ==========================================
// Management frame
`define MDIO_FRAME_BITS 7'h40
`define MDIO_TA_BIT 7'h2E
`define MDIO_DATA_BIT 7'h30
`define MDIO_START 2'h1
`define MDIO_OP_READ 2'h2
`define MDIO_OP_WRITE 2'h1
`define MDC_HALF_CYCLES 4'h2
// ==========================================
// Receive hash
`define CRC_INIT 32'hFFFFFFFF
`define CRC_POLY 32'h04C11DB7
`define DA_BYTES 3'h6
`endif

// ### sim/station_filter_sva.sv
`timescale 1ns/1ps
// ==========
// Checker
module station_filter_sva #(
    parameter MDC_HALF = 2
) (
    input wire clk,
    input wire rst,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [31:0] hwdata,
    input wire hready,
    input wire ee_done,
    input wire init_done,
    input wire da_done,
    input wire group_frame,
    input wire group_accept,
    input wire mdc,
    input wire mdio_out,
    input wire mdio_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    reg acc_wr;
    reg [7:0] hcnt;
    always @(posedge clk) begin
        acc_wr <= !rst && hsel && htrans[1] && hready && hwrite && haddr == 32'h18;
        hcnt <= (rst || !mdc) ? 8'h0 : hcnt + 8'h1;
    end
    sequence s_start;
        acc_wr && hwdata[0];
    endsequence
    sequence s_preamble;
        mdio_out [*8];
    endsequence
    property p_start; s_start |-> ##[1:8] mdio_oe; endproperty
    a_start: assert property (p_start) else $error("no frame");
    property p_pre; $rose(mdio_oe) |-> s_preamble; endproperty
    a_pre: assert property (p_pre) else $error("bad preamble");
    property p_half; $fell(mdc) |-> hcnt == MDC_HALF; endproperty
    a_half: assert property (p_half) else $error("bad mdc");
    property p_init; ee_done |=> init_done; endproperty
    a_init: assert property (p_init) else $error("no init");
    property p_keep; init_done |=> init_done; endproperty
    a_keep: assert property (p_keep) else $error("init lost");
    property p_rel; $fell(rst) |-> !init_done && !mdio_oe; endproperty
    a_rel: assert property (p_rel) else $error("bad reset");
    property p_da; da_done |=> !da_done; endproperty
    a_da: assert property (p_da) else $error("long pulse");
    property p_grp; da_done && group_accept |-> group_frame; endproperty
    a_grp: assert property (p_grp) else $error("bad accept");
endmodule // station_filter_sva

bind station_filter station_filter_sva #(.MDC_HALF(MDC_HALF)) station_filter_sva_inst (
    .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hwdata(hwdata), .hready(hready), .ee_done(ee_done), .init_done(init_done),
    .da_done(da_done), .group_frame(group_frame), .group_accept(group_accept),
    .mdc(mdc), .mdio_out(mdio_out), .mdio_oe(mdio_oe)
);

// ### sim/phy_mgmt_model.sv
`timescale 1ns/1ps
// ==========
// Phy model
module phy_mgmt_model (
    input wire mdc,
    input wire mdio_out,
    input wire mdio_oe,
    output wire mdio_in
);
    reg [15:0] regs [0:31];
    reg [15:0] sh = 16'h0;
    reg [4:0] ra = 5'h0;
    reg rd = 0, wr = 0, drv = 0, dbit = 1;
    integer cnt = 0, i;
    // Pull-up when nobody drives
    assign mdio_in = mdio_oe ? mdio_out : (drv ? dbit : 1'b1);
    initial for (i = 0; i < 32; i = i + 1) regs[i] = 16'hA500 | i;
    always @(posedge mdc) begin
        sh = {sh[14:0], mdio_in};
        if (cnt != 0)
            cnt = cnt + 1;
        else if (sh[7:0] == 8'hFD && mdio_oe)
            cnt = 1;
        if (cnt == 13) begin
            rd = sh[11:10] == 2'b10 && sh[9:5] == 5'h01;
            wr = sh[11:10] == 2'b01 && sh[9:5] == 5'h01;
            ra = sh[4:0];
        end
        if (cnt == 31) begin
            if (wr)
                regs[ra] = sh;
            cnt = 0;
            rd = 0;
            wr = 0;
        end
    end
    always @(negedge mdc) begin
        drv <= rd && cnt >= 14 && cnt <= 30;
        dbit <= cnt < 15 ? 1'b0 : regs[ra][30 - cnt];
    end
endmodule // phy_mgmt_model

// ### sim/station_filter_tb_top.sv
`timescale 1ns/1ps
`include "station_filter_defs.vh"
// ==========
// Bench
module station_filter_tb_top;
    reg clk = 0, rst = 1, hsel = 0, hwrite = 0, ee_programmed = 0, ee_valid = 0;
    reg ee_done = 0, rx_start = 0, rx_valid = 0;
    reg [31:0] haddr = 0, hwdata = 0, q;
    reg [1:0] htrans = 0;
    reg [2:0] ee_loc = 0;
    reg [7:0] ee_data = 0, rx_byte = 0;
    wire hreadyout, init_done, da_done, station_match, group_frame, group_accept;
    wire mdc, mdio_out, mdio_oe, mdio_in;
    wire [31:0] hrdata;
    integer failures = 0, n_compared = 0;
    localparam [47:0] mac0 = 48'h123456789ABC;
    localparam [47:0] grp = 48'h01005E0000FB;
    always #50 clk = ~clk;
    station_filter #(.MDC_HALF(1)) station_filter_inst (.clk(clk), .rst(rst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(), .hrdata(hrdata),
        .ee_programmed(ee_programmed), .ee_valid(ee_valid), .ee_loc(ee_loc),
        .ee_data(ee_data), .ee_done(ee_done), .init_done(init_done), .rx_start(rx_start),
        .rx_valid(rx_valid), .rx_byte(rx_byte), .da_done(da_done),
        .station_match(station_match), .group_frame(group_frame),
        .group_accept(group_accept), .mdc(mdc), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
        .mdio_in(mdio_in));
    phy_mgmt_model phy_mgmt_model_inst (.mdc(mdc), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
        .mdio_in(mdio_in));
    task chk(input [31:0] g, input [31:0] e);
        begin
            n_compared = n_compared + 1;
            if (g !== e) begin
                failures = failures + 1;
                $display("MISMATCH t=%0t seen=%h exp=%h", $time, g, e);
            end
        end
    endtask
    task bus(input w, input [3:0] i, input [31:0] d);
        integer n;
        begin
            @(posedge clk);
            hsel <= 1'b1;
            htrans <= 2'h2;
            hwrite <= w;
            haddr <= {26'h0, i, 2'h0};
            for (n = 0; n < 2; n = n + 1) begin
                @(posedge clk);
                while (hreadyout !== 1'b1) @(posedge clk);
                hsel <= 1'b0;
                htrans <= 2'h0;
                hwdata <= d;
            end
            q = hrdata;
        end
    endtask
    task rc(input [3:0] i, input [31:0] e);
        begin
            bus(1'b0, i, 32'h0);
            chk(q, e);
        end
    endtask
    task do_rst;
        begin
            rst <= 1'b1;
            repeat (8) @(posedge clk);
            rst <= 1'b0;
        end
    endtask
    task t_regs;
        integer i;
        begin
            for (i = 1; i < 9; i = i + 1)
                rc(i[3:0], i == 2 ? 32'hFFF : i == 3 ? 32'h0FFFFFFF : 32'h0);
            bus(1'b1, 4'h2, 32'h1234);
            rc(4'h2, 32'hFFF);
            $display("regs done");
        end
    endtask
    task t_ee(input p);
        integer k;
        begin
            do_rst;
            ee_programmed <= p;
            for (k = 1; k < 7; k = k + 1) begin
                @(posedge clk);
                ee_valid <= 1'b1;
                ee_loc <= k[2:0];
                ee_data <= mac0[(6 - k) * 8 +: 8];
            end
            @(posedge clk);
            ee_valid <= 1'b0;
            ee_done <= 1'b1;
            @(posedge clk);
            ee_done <= 1'b0;
            rc(4'h3, p ? 32'h78563412 : 32'h0FFFFFFF);
            rc(4'h2, p ? 32'hBC9A : 32'hFFF);
            chk(init_done, 1);
            bus(1'b1, 4'h2, 32'hDEF0);
            rc(4'h2, 32'hDEF0);
            $display("eeprom done");
        end
    endtask
    task rx(input [47:0] a);
        integer k;
        begin
            @(posedge clk);
            rx_start <= 1'b1;
            for (k = 0; k < 6; k = k + 1) begin
                @(posedge clk);
                rx_start <= 1'b0;
                rx_valid <= 1'b1;
                rx_byte <= a[47 - 8 * k -: 8];
            end
            @(posedge clk);
            rx_valid <= 1'b0;
            @(posedge clk);
            while (da_done !== 1'b1) @(posedge clk);
        end
    endtask
    function [5:0] hidx(input [47:0] a);
        reg [31:0] c;
        integer b;
        begin
            c = 32'hFFFFFFFF;
            for (b = 0; b < 48; b = b + 1)
                c = {c[30:0], 1'b0} ^ ((c[31] ^ a[40 - 8 * (b / 8) + b % 8]) ? 32'h04C11DB7 : 0);
            hidx = c[31:26];
        end
    endfunction
    task t_rx;
        reg [5:0] i;
        begin
            rx(48'h12345678F0DE);
            chk(station_match, 1);
            chk(group_frame, 0);
            rx(48'hDEF078563412);
            chk(station_match, 0);
            i = hidx(grp);
            bus(1'b1, i[5] ? 4'h4 : 4'h5, 32'h1 << i[4:0]);
            bus(1'b1, i[5] ? 4'h5 : 4'h4, 32'h0);
            rx(grp);
            chk(group_accept, 1);
            bus(1'b1, i[5] ? 4'h4 : 4'h5, ~(32'h1 << i[4:0]));
            bus(1'b1, i[5] ? 4'h5 : 4'h4, 32'hFFFFFFFF);
            rx(grp);
            chk(group_accept, 0);
            bus(1'b1, 4'h1, 32'h1);
            rx(grp);
            chk(group_accept, 1);
            $display("receive done");
        end
    endtask
    task idle;
        begin
            bus(1'b0, 4'h6, 32'h0);
            while (q[0] !== 1'b0) bus(1'b0, 4'h6, 32'h0);
        end
    endtask
    task t_mdio;
        begin
            bus(1'b1, 4'h7, 32'h5A5A);
            bus(1'b1, 4'h6, 32'h08C3);
            rc(4'h6, 32'h08C3);
            idle;
            chk(phy_mgmt_model_inst.regs[3], 32'h5A5A);
            bus(1'b1, 4'h6, 32'h0941);
            idle;
            rc(4'h7, 32'hA505);
            bus(1'b1, 4'h6, 32'h08C1);
            idle;
            rc(4'h7, 32'h5A5A);
            $display("management done");
        end
    endtask
    task close_out;
        begin
            $display("compared=%0d failures=%0d", n_compared, failures);
            if (failures == 0 && n_compared > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        failures = failures + 1;
        close_out;
    end
    initial begin
        do_rst;
        t_regs;
        t_ee(1'b0);
        t_ee(1'b1);
        t_rx;
        t_mdio;
        close_out;
    end
endmodule // station_filter_tb_top
